// [rtl/pjrc_defs.vh]
// Shared constants of the PWM block with job request control
`ifndef PJRC_DEFS_VH
`define PJRC_DEFS_VH

// Clock and time base
`define PJRC_CLK_PERIOD_NS  50
`define PJRC_TB_FINE_NS     100000
`define PJRC_TB_COARSE_NS   1000000
`define PJRC_FINE_TICK_CYC   16'h07d0
`define PJRC_COARSE_TICK_CYC 16'h4e20

// Channels
`define PJRC_NUM_CH         2'h3
`define PJRC_MAX_CH_SEL     16'h0003

// Job codes
`define PJRC_JOB_NOP        16'h0000
`define PJRC_JOB_WR_PERIOD  16'h0001
`define PJRC_JOB_WR_DELAY   16'h0002
`define PJRC_JOB_WR_MINP    16'h0004
`define PJRC_JOB_RD_PERIOD  16'h0081
`define PJRC_JOB_RD_DELAY   16'h0082
`define PJRC_JOB_RD_MINP    16'h0084

// Fault codes
`define PJRC_ERR_NONE       16'h0000
`define PJRC_ERR_PER_LOW    16'h0411
`define PJRC_ERR_PER_HIGH   16'h0412
`define PJRC_ERR_DLY_LOW    16'h0421
`define PJRC_ERR_DLY_HIGH   16'h0422
`define PJRC_ERR_MINP_LOW   16'h0431
`define PJRC_ERR_MINP_HIGH  16'h0432
`define PJRC_ERR_BAD_JOB    16'h04ff
`define PJRC_ERR_PARAM      16'h8001
`define PJRC_ERR_BAD_CH     16'h8009

// Setting ranges in time-base units, signed 32-bit compare
`define PJRC_PER_MIN_FINE   32'h0000_0004
`define PJRC_PER_MIN_COARSE 32'h0000_0001
`define PJRC_TIME_MAX       32'h0000_ffff
`define PJRC_DLY_MIN        32'h0000_0000
`define PJRC_MINP_MIN_FINE  32'h0000_0002
`define PJRC_MINP_MIN_CRS   32'h0000_0000

// Reset values of the settings
`define PJRC_RST_PERIOD     16'h4e20
`define PJRC_RST_DELAY      16'h0000
`define PJRC_RST_MINP       16'h0002

// Duty full scales
`define PJRC_FS_PERMIL      16'h03e8
`define PJRC_FS_ANALOG      16'h6c00

// Channel sequencer states
`define PJRC_ST_IDLE        2'h0
`define PJRC_ST_DELAY       2'h1
`define PJRC_ST_RUN         2'h2

`endif

// [rtl/pjrc_tick.v]
// Time-base tick generator, one pulse every reload cycles
`timescale 1ns/1ps
`default_nettype none
module pjrc_tick (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [15:0] reload,
  output reg         tick_reg
);

  reg  [15:0] cnt_reg;
  wire [15:0] cnt_inc;

  assign cnt_inc = cnt_reg + 16'h0001;

  // Free-running divider
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (cnt_inc >= reload) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_inc;
      tick_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/pjrc_channel.v]
// One PWM channel: on-delay, period sequencing and pulse shaping
`timescale 1ns/1ps
`default_nettype none
`include "pjrc_defs.vh"
module pjrc_channel (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        tick,
  input  wire        gate,
  input  wire [15:0] duty,
  input  wire        analog,
  input  wire [15:0] period,
  input  wire [15:0] on_delay,
  input  wire [15:0] min_pulse,
  output reg         pwm_reg
);

  reg  [1:0]  state_reg;
  reg  [15:0] cnt_reg;
  reg  [15:0] per_reg;
  reg  [15:0] pul_reg;
  wire [15:0] full_scale;
  wire [15:0] duty_pos;
  wire [15:0] duty_lim;
  wire [31:0] prod;
  wire [31:0] quot;
  wire [15:0] raw_pulse;
  wire [15:0] pause;
  wire [15:0] shaped;
  wire [15:0] cnt_inc;

  assign full_scale = analog ? `PJRC_FS_ANALOG : `PJRC_FS_PERMIL;
  assign duty_pos   = duty[15] ? 16'h0000 : duty;
  assign duty_lim   = (duty_pos > full_scale) ? full_scale : duty_pos;
  assign prod       = duty_lim * period;
  assign quot       = prod / {16'h0000, full_scale};
  assign raw_pulse  = quot[15:0];
  assign pause      = period - raw_pulse;
  assign shaped     = (raw_pulse < min_pulse) ? 16'h0000 :
                      (pause < min_pulse) ? period : raw_pulse;
  assign cnt_inc    = cnt_reg + 16'h0001;

  // Sequencer: idle, on-delay, running periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `PJRC_ST_IDLE;
      cnt_reg   <= 16'h0000;
      per_reg   <= `PJRC_RST_PERIOD;
      pul_reg   <= 16'h0000;
      pwm_reg   <= 1'b0;
    end else if (!gate) begin
      state_reg <= `PJRC_ST_IDLE;
      pwm_reg   <= 1'b0;
    end else begin
      case (state_reg)
        `PJRC_ST_IDLE: begin
          if (on_delay == 16'h0000) begin
            state_reg <= `PJRC_ST_RUN;
            cnt_reg   <= 16'h0000;
            per_reg   <= period;
            pul_reg   <= shaped;
            pwm_reg   <= (shaped != 16'h0000);
          end else begin
            state_reg <= `PJRC_ST_DELAY;
            cnt_reg   <= on_delay;
            pwm_reg   <= 1'b0;
          end
        end
        `PJRC_ST_DELAY: begin
          if (tick) begin
            if (cnt_reg == 16'h0001) begin
              state_reg <= `PJRC_ST_RUN;
              cnt_reg   <= 16'h0000;
              per_reg   <= period;
              pul_reg   <= shaped;
              pwm_reg   <= (shaped != 16'h0000);
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        `PJRC_ST_RUN: begin
          if (tick) begin
            if (cnt_inc >= per_reg) begin
              cnt_reg <= 16'h0000;
              per_reg <= period;
              pul_reg <= shaped;
              pwm_reg <= (shaped != 16'h0000);
            end else begin
              cnt_reg <= cnt_inc;
              pwm_reg <= (cnt_inc < pul_reg);
            end
          end
        end
        default: begin
          state_reg <= `PJRC_ST_IDLE;
          pwm_reg   <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [rtl/pjrc_top.v]
// Three-channel PWM unit with a job request interface for its settings
`timescale 1ns/1ps
`default_nettype none
`include "pjrc_defs.vh"
// What this block does
// - A job starts only on a rising edge of the job request.
// - A job is executed in the clock cycle its request edge is seen.
// - Job code zero is accepted and changes nothing.
// - Codes 01h, 02h, 04h write period, on-delay, minimum pulse.
// - Codes 81h, 82h, 84h return period, on-delay, minimum pulse.
// - The write value is a full-range signed 32-bit number.
// - A read job leaves the setting on the read-value output.
// - A failed job raises the fault flag with a cause code; success 0000h.
// - Period write below range gives 0411h, above range 0412h.
// - On-delay write below range gives 0421h, above range 0422h.
// - Minimum pulse write below range 0431h, above range 0432h.
// - Any undefined job code on channels 0 to 2 is refused with 04FFh.
// - Channel above 3 is refused with 8009h and touches no channel.
// - Channel 3, just beyond the built channels, is refused with 8001h.
// - The internal gate follows the software gate enable directly.
// - The gate state output shows the internal gate.
// - New settings apply from the next period; running period completes.
// - The block raises no interrupt of any kind.
// - Pulse is duty over 1000 or 27648 times the period.
// - After gate opening the output stays low for the on-delay.
// - Pulses or pauses shorter than the minimum pulse are removed.
module pjrc_top #(
  parameter [15:0] COARSE_TICK_CYC = `PJRC_COARSE_TICK_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [2:0]  gate_enable,
  input  wire [15:0] duty_value_ch0,
  input  wire [15:0] duty_value_ch1,
  input  wire [15:0] duty_value_ch2,
  input  wire        format_analog,
  input  wire        timebase_coarse,
  input  wire        job_request,
  input  wire [15:0] channel_select,
  input  wire [15:0] job_code,
  input  wire [31:0] job_write_value,
  output reg  [2:0]  gate_state_reg,
  output wire [2:0]  pwm_out,
  output reg         job_done_reg,
  output reg         job_fault_reg,
  output reg  [15:0] fault_code_reg,
  output reg  [31:0] job_read_value_reg
);

  // Tick interval of the fine time base
  localparam [15:0] FINE_TICK_CYC = `PJRC_FINE_TICK_CYC;

  // Settings per channel, in time-base units
  reg  [15:0] period_reg [0:2];
  reg  [15:0] delay_reg  [0:2];
  reg  [15:0] minp_reg   [0:2];

  // Job request edge detection
  reg         job_req_prev_reg;
  wire        job_start;

  // Job evaluation results
  reg         fault_next;
  reg  [15:0] code_next;
  reg  [31:0] read_next;
  reg         wr_per_next;
  reg         wr_dly_next;
  reg         wr_minp_next;

  // Channel selection decode
  wire        ch_over_max;
  wire        ch_not_built;
  wire [1:0]  ch_idx;
  wire [1:0]  ch_safe;

  // Settings of the selected channel
  wire [15:0] sel_period;
  wire [15:0] sel_delay;
  wire [15:0] sel_minp;

  // Write strobes of accepted jobs
  wire        wr_per_stb;
  wire        wr_dly_stb;
  wire        wr_minp_stb;

  // Value and bounds for range checks
  wire signed [31:0] wr_val;
  wire signed [31:0] per_min;
  wire signed [31:0] minp_min;
  wire signed [31:0] minp_max;
  wire signed [31:0] time_max;
  wire signed [31:0] dly_min;

  // Time-base tick
  wire [15:0] tick_reload;
  wire        tick;

  // Duty values gathered for the channel instances
  wire [15:0] duty_bus [0:2];

  assign duty_bus[0] = duty_value_ch0;
  assign duty_bus[1] = duty_value_ch1;
  assign duty_bus[2] = duty_value_ch2;

  // Tick source for all channels
  assign tick_reload = timebase_coarse ? COARSE_TICK_CYC : FINE_TICK_CYC;

  pjrc_tick u_tick (
    .clk      (clk),
    .rst_n    (rst_n),
    .reload   (tick_reload),
    .tick_reg (tick)
  );

  // rising edge only starts a job
  assign job_start = job_request & ~job_req_prev_reg;

  // Request history for edge detection
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      job_req_prev_reg <= 1'b0;
    end else begin
      job_req_prev_reg <= job_request;
    end
  end

  // Channel number checks, negative counts as too large
  assign ch_over_max  = channel_select[15] ||
                        (channel_select > `PJRC_MAX_CH_SEL);
  assign ch_not_built = (channel_select[1:0] >= `PJRC_NUM_CH);
  assign ch_idx       = channel_select[1:0];

  // Unbuilt channel never indexes the setting arrays
  assign ch_safe = ch_not_built ? 2'h0 : ch_idx;

  // Setting words of the selected channel
  assign sel_period = period_reg[ch_safe];
  assign sel_delay  = delay_reg[ch_safe];
  assign sel_minp   = minp_reg[ch_safe];

  assign wr_val   = job_write_value;
  assign time_max = `PJRC_TIME_MAX;
  assign dly_min  = `PJRC_DLY_MIN;
  assign per_min  = timebase_coarse ? `PJRC_PER_MIN_COARSE
                                    : `PJRC_PER_MIN_FINE;
  assign minp_min = timebase_coarse ? `PJRC_MINP_MIN_CRS
                                    : `PJRC_MINP_MIN_FINE;
  assign minp_max = {17'h00000, sel_period[15:1]};

  // Job evaluation, decided within one cycle
  always @* begin
    fault_next   = 1'b0;
    code_next    = `PJRC_ERR_NONE;
    read_next    = job_read_value_reg;
    wr_per_next  = 1'b0;
    wr_dly_next  = 1'b0;
    wr_minp_next = 1'b0;
    if (ch_over_max) begin
      fault_next = 1'b1;
      code_next  = `PJRC_ERR_BAD_CH;
    end else if (ch_not_built) begin
      fault_next = 1'b1;
      code_next  = `PJRC_ERR_PARAM;
    end else begin
      case (job_code)
        `PJRC_JOB_NOP: begin
          fault_next = 1'b0;
        end
        `PJRC_JOB_WR_PERIOD: begin
          if (wr_val < per_min) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_PER_LOW;
          end else if (wr_val > time_max) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_PER_HIGH;
          end else begin
            wr_per_next = 1'b1;
          end
        end
        `PJRC_JOB_WR_DELAY: begin
          if (wr_val < dly_min) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_DLY_LOW;
          end else if (wr_val > time_max) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_DLY_HIGH;
          end else begin
            wr_dly_next = 1'b1;
          end
        end
        `PJRC_JOB_WR_MINP: begin
          if (wr_val < minp_min) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_MINP_LOW;
          end else if (wr_val > minp_max) begin
            fault_next = 1'b1;
            code_next  = `PJRC_ERR_MINP_HIGH;
          end else begin
            wr_minp_next = 1'b1;
          end
        end
        `PJRC_JOB_RD_PERIOD: begin
          read_next = {16'h0000, sel_period};
        end
        `PJRC_JOB_RD_DELAY: begin
          read_next = {16'h0000, sel_delay};
        end
        `PJRC_JOB_RD_MINP: begin
          read_next = {16'h0000, sel_minp};
        end
        default: begin
          fault_next = 1'b1;
          code_next  = `PJRC_ERR_BAD_JOB;
        end
      endcase
    end
  end

  assign wr_per_stb  = job_start & wr_per_next;
  assign wr_dly_stb  = job_start & wr_dly_next;
  assign wr_minp_stb = job_start & wr_minp_next;

  // Period settings, written by accepted jobs only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_reg[0] <= `PJRC_RST_PERIOD;
      period_reg[1] <= `PJRC_RST_PERIOD;
      period_reg[2] <= `PJRC_RST_PERIOD;
    end else if (wr_per_stb) begin
      period_reg[ch_safe] <= job_write_value[15:0];
    end
  end

  // On-delay settings, written by accepted jobs only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_reg[0] <= `PJRC_RST_DELAY;
      delay_reg[1] <= `PJRC_RST_DELAY;
      delay_reg[2] <= `PJRC_RST_DELAY;
    end else if (wr_dly_stb) begin
      delay_reg[ch_safe] <= job_write_value[15:0];
    end
  end

  // Minimum pulse settings, written by accepted jobs only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      minp_reg[0] <= `PJRC_RST_MINP;
      minp_reg[1] <= `PJRC_RST_MINP;
      minp_reg[2] <= `PJRC_RST_MINP;
    end else if (wr_minp_stb) begin
      minp_reg[ch_safe] <= job_write_value[15:0];
    end
  end

  // results are polled; no interrupt source exists
  // Job result outputs, held until the next job
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      job_fault_reg      <= 1'b0;
      fault_code_reg     <= `PJRC_ERR_NONE;
      job_read_value_reg <= 32'h0000_0000;
    end else if (job_start) begin
      // job finished in the request cycle
      job_fault_reg      <= fault_next;
      fault_code_reg     <= code_next;
      job_read_value_reg <= read_next;
    end
  end

  // Completion flag, low for the job cycle only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      job_done_reg <= 1'b1;
    end else if (job_start) begin
      job_done_reg <= 1'b0;
    end else begin
      job_done_reg <= 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_state_reg <= 3'h0;
    end else begin
      gate_state_reg <= gate_enable;
    end
  end

  // One sequencer per built channel
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
      pjrc_channel u_ch (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .gate      (gate_state_reg[gi]),
        .duty      (duty_bus[gi]),
        .analog    (format_analog),
        .period    (period_reg[gi]),
        .on_delay  (delay_reg[gi]),
        .min_pulse (minp_reg[gi]),
        .pwm_reg   (pwm_out[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// [sim/pjrc_assertions.sv]
// Checker for the PWM job request block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pjrc_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  gate_enable,
  input wire logic        job_request,
  input wire logic [15:0] channel_select,
  input wire logic [15:0] job_code,
  input wire logic [2:0]  gate_state_reg,
  input wire logic [2:0]  pwm_out,
  input wire logic        job_done_reg,
  input wire logic        job_fault_reg,
  input wire logic [15:0] fault_code_reg,
  input wire logic [31:0] job_read_value_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Defined job codes
  wire code_ok = job_code inside {16'h0, 16'h1, 16'h2, 16'h4, 16'h81,
                                  16'h82, 16'h84};
  // Job accepted on a request edge, then a one-cycle done drop
  sequence job_taken;
    job_request && !$past(job_request);
  endsequence
  sequence done_pulse;
    !job_done_reg ##1 job_done_reg;
  endsequence
  chk_job_done: assert property (job_taken |=> done_pulse)
    else $error("job done pulse missing");
  chk_done_cause: assert property (!job_done_reg |->
    $past(job_request) && !$past(job_request, 2))
    else $error("job done dropped without request edge");
  chk_bad_chan: assert property (job_taken ##0 channel_select > 16'h3
    |=> job_fault_reg && fault_code_reg == 16'h8009)
    else $error("bad channel not refused");
  chk_chan_three: assert property (job_taken ##0 channel_select == 16'h3
    |=> job_fault_reg && fault_code_reg == 16'h8001)
    else $error("unbuilt channel not refused");
  chk_bad_code: assert property (job_taken ##0
    (channel_select < 16'h3 && !code_ok) |=> fault_code_reg == 16'h04ff)
    else $error("unknown job code not refused");
  chk_fault_flag: assert property (
    job_fault_reg == (fault_code_reg != 16'h0))
    else $error("fault flag and code disagree");
  chk_result_hold: assert property (job_done_reg |->
    $stable(job_read_value_reg) && $stable(fault_code_reg))
    else $error("job result changed without job");
  chk_gate_copy: assert property (
    gate_state_reg == $past(gate_enable))
    else $error("gate state does not follow gate");
  chk_pwm_gated: assert property (
    (pwm_out & ~$past(gate_state_reg)) == 3'h0)
    else $error("pwm active with gate closed");
endmodule
bind pjrc_top pjrc_checker u_chk (.clk, .rst_n, .gate_enable, .job_request,
  .channel_select, .job_code, .gate_state_reg, .pwm_out, .job_done_reg,
  .job_fault_reg, .fault_code_reg, .job_read_value_reg);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the PWM job request block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  gate_enable = 3'h0;
  logic [15:0] duty_value_ch0 = 16'h0;
  logic [15:0] duty_value_ch1 = 16'h01f4;
  logic [15:0] duty_value_ch2 = 16'hfc18;
  logic        format_analog = 1'b0;
  logic        timebase_coarse = 1'b0;
  logic        job_request = 1'b0;
  logic [15:0] channel_select = 16'h0;
  logic [15:0] job_code = 16'h0;
  logic [31:0] job_write_value = 32'h0;
  // outputs are only observed, never driven
  logic [2:0]  gate_state_reg;
  logic [2:0]  pwm_out;
  logic        job_done_reg;
  logic        job_fault_reg;
  logic [15:0] fault_code_reg;
  logic [31:0] job_read_value_reg;
  logic [79:0] ftab [13];
  int          num_errors = 0;
  int          tests_run = 0;
  int          n;
  pjrc_top #(.COARSE_TICK_CYC(16'h0014)) dut (.clk, .rst_n, .gate_enable,
    .duty_value_ch0, .duty_value_ch1, .duty_value_ch2, .format_analog,
    .timebase_coarse, .job_request, .channel_select, .job_code,
    .job_write_value, .gate_state_reg, .pwm_out, .job_done_reg,
    .job_fault_reg, .fault_code_reg, .job_read_value_reg);
  // 20 MHz clock
  always #25 clk = ~clk;
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Drive just after the rising edge
  task step;
    @(posedge clk);
    #1;
  endtask
  // One job with its done pulse and fault report
  // each job starts after done is seen high again
  task job(input logic [15:0] ch, input logic [15:0] code,
           input logic [31:0] val, input logic [15:0] ef);
    channel_select = ch;
    job_code = code;
    job_write_value = val;
    job_request = 1'b1;
    step;
    chk(job_done_reg, 1'b0);
    chk(job_fault_reg, ef != 16'h0);
    chk(fault_code_reg, ef);
    job_request = 1'b0;
    step;
    chk(job_done_reg, 1'b1);
  endtask
  task rd(input logic [15:0] ch, input logic [15:0] code,
          input logic [31:0] exp);
    job(ch, code, 32'h0, 16'h0);
    chk(job_read_value_reg, exp);
  endtask
  // High cycles of channel 0 over three settled periods
  task meas(input int exp);
    n = 0;
    repeat (400) step;
    repeat (600) begin
      step;
      if (pwm_out[0] === 1'b1) n++;
    end
    chk(n, exp);
    chk(pwm_out[2], 1'b0);
  endtask
  // Main sequence
  initial begin
    ftab = '{{16'h1, 16'h1, 32'h3, 16'h0411},
      {16'h1, 16'h1, 32'h8000_0000, 16'h0411},
      {16'h1, 16'h1, 32'h1_0000, 16'h0412},
      {16'h1, 16'h1, 32'h7fff_ffff, 16'h0412},
      {16'h1, 16'h2, 32'hffff_ffff, 16'h0421},
      {16'h1, 16'h2, 32'h1_0000, 16'h0422},
      {16'h1, 16'h4, 32'h1, 16'h0431}, {16'h1, 16'h4, 32'h33, 16'h0432},
      {16'h1, 16'h3, 32'h0, 16'h04ff}, {16'h1, 16'h83, 32'h0, 16'h04ff},
      {16'h4, 16'h1, 32'h64, 16'h8009}, {16'hffff, 16'h1, 32'h64, 16'h8009},
      {16'h3, 16'h1, 32'h64, 16'h8001}};
    repeat (6) step;
    rst_n = 1'b1;
    step;
    chk(job_done_reg, 1'b1);
    chk(job_read_value_reg, 32'h0);
    for (logic [15:0] c = 0; c < 3; c++) begin
      rd(c, 16'h81, 32'h4e20);
      rd(c, 16'h82, 32'h0);
      rd(c, 16'h84, 32'h2);
    end
    job(16'h1, 16'h1, 32'h64, 16'h0);
    job(16'h1, 16'h2, 32'h3, 16'h0);
    job(16'h1, 16'h4, 32'h5, 16'h0);
    rd(16'h1, 16'h82, 32'h3);
    rd(16'h1, 16'h84, 32'h5);
    job(16'h1, 16'h0, 32'h1, 16'h0);
    chk(job_read_value_reg, 32'h5);
    foreach (ftab[i]) job(ftab[i][79:64], ftab[i][63:48], ftab[i][47:16],
      ftab[i][15:0]);
    rd(16'h1, 16'h81, 32'h64);
    job(16'h1, 16'h4, 32'h32, 16'h0);
    rd(16'h1, 16'h84, 32'h32);
    timebase_coarse = 1'b1;
    job(16'h0, 16'h1, 32'h0, 16'h0411);
    // Held request starts one job only
    channel_select = 16'h0;
    job_code = 16'h1;
    job_write_value = 32'ha;
    job_request = 1'b1;
    n = 0;
    repeat (6) begin
      step;
      if (job_done_reg === 1'b0) n++;
    end
    chk(n, 1);
    job_request = 1'b0;
    step;
    job(16'h0, 16'h4, 32'h0, 16'h0);
    // Waveform checks on channel 0, period 10 ticks of 20 cycles
    duty_value_ch0 = 16'h01f4;
    gate_enable = 3'h7;
    step;
    chk(gate_state_reg, 3'h7);
    meas(300);
    duty_value_ch0 = 16'h03e8;
    meas(600);
    format_analog = 1'b1;
    duty_value_ch0 = 16'h2066;
    meas(120);
    job(16'h0, 16'h4, 32'h3, 16'h0);
    meas(0);
    format_analog = 1'b0;
    duty_value_ch0 = 16'h0320;
    meas(600);
    gate_enable = 3'h0;
    step;
    step;
    chk(gate_state_reg, 3'h0);
    chk(pwm_out, 3'h0);
    // On-delay of 20 ticks before the first pulse
    job(16'h0, 16'h2, 32'h14, 16'h0);
    gate_enable = 3'h1;
    n = 0;
    while (pwm_out[0] !== 1'b1 && n < 600) begin
      step;
      n++;
    end
    chk(n >= 380 && n <= 420, 1'b1);
    gate_enable = 3'h0;
    step;
    step;
    // Second reset restores the settings
    rst_n = 1'b0;
    repeat (6) step;
    rst_n = 1'b1;
    step;
    rd(16'h0, 16'h81, 32'h4e20);
    test_done;
  end
endmodule
`default_nettype wire
